// ===== rtl/ifcr_pkg.sv
// Package for the interrupt flag and control register group.
// Assumes an AXI4-Lite master with 32-bit data; registers are 16 bits in the low half.
package ifcr_pkg;
	// Byte offsets of the registers
	localparam logic [7:0] IFCR_OFF_CTRL1  = 8'h00;
	localparam logic [7:0] IFCR_OFF_CTRL2  = 8'h04;
	localparam logic [7:0] IFCR_OFF_FLAGS0 = 8'h08;
	localparam logic [7:0] IFCR_OFF_FLAGS1 = 8'h0C;
	localparam logic [7:0] IFCR_OFF_FLAGS3 = 8'h10;
	localparam logic [7:0] IFCR_OFF_FLAGS4 = 8'h14;
	localparam logic [7:0] IFCR_OFF_EN0    = 8'h18;
	localparam logic [7:0] IFCR_OFF_EN1    = 8'h1C;
	localparam logic [7:0] IFCR_OFF_EN3    = 8'h20;
	localparam logic [7:0] IFCR_OFF_EN4    = 8'h24;
	localparam logic [7:0] IFCR_OFF_PRIO   = 8'h28;

	// Implemented-bit masks; everything else reads 0
	localparam logic [15:0] IFCR_MASK_CTRL1  = 16'h0006;
	localparam logic [15:0] IFCR_MASK_CTRL2  = 16'hC007;
	localparam logic [15:0] IFCR_MASK_CTRL2W = 16'h8007;
	localparam logic [15:0] IFCR_MASK_FLAGS0 = 16'h3FEF;
	localparam logic [15:0] IFCR_MASK_FLAGS1 = 16'h20DB;
	localparam logic [15:0] IFCR_MASK_FLAGS3 = 16'h8600;
	localparam logic [15:0] IFCR_MASK_FLAGS4 = 16'h0602;

	// Field positions
	localparam int IFCR_BIT_STACK_TRAP = 2;
	localparam int IFCR_BIT_OSC_TRAP   = 1;
	localparam int IFCR_BIT_ALT_VEC    = 15;
	localparam int IFCR_BIT_DIS_INSTR  = 14;
	localparam int IFCR_BIT_EXT0_FLAG  = 0;
	localparam int IFCR_BIT_EXT1_FLAG  = 4;
	localparam int IFCR_BIT_EXT2_FLAG  = 13;

	localparam logic [15:0] IFCR_RESET_VAL = 16'h0000;
	localparam logic [2:0]  IFCR_PRIO_OFF  = 3'h0;
	localparam logic [1:0]  IFCR_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  IFCR_RESP_SLVERR = 2'h2;
	localparam int IFCR_NSRC = 64;
endpackage

// ===== rtl/ifcr_regs.sv
// Interrupt flag and control registers behind an AXI4-Lite slave.
// Assumes sources pulse on aclk except ext_irq_pin, which is asynchronous.
//
// Functional notes
// [R1] Stack error trap event sets the stack trap bit, bit 2.
// [R2] Oscillator failure trap event sets the oscillator trap bit, bit 1.
// [R3] Alternate vector table select bit 15 drives the table choice output.
// [R4] Bit 14 reflects disable-interrupts instruction activity; writes ignored.
// [R5] Polarity bit 1 detects negative edge, 0 positive, per external input.
// [R6] Second control register bits 13 to 3 read zero.
// [R7] Flag bits read 1 after request, software can read and write them.
// [R8] All implemented bits zero after reset; unimplemented bits read zero.
// [R9] Flags0 bit 13 is ADC done; bits 15,14 unimplemented.
// [R10] Flags0 bit 12 UART transmit, bit 11 UART receive.
// [R11] Flags0 bit 10 SPI event, bit 9 SPI fault.
// [R12] Flags0 bit 8 timer c, bit 7 timer b, bit 3 timer a.
// [R13] Flags0 bit 6 compare b, bit 2 compare a.
// [R14] Flags0 bit 5 capture b, bit 1 capture a.
// [R15] External flags: flags0 bit 0, flags1 bits 4 and 13.
// [R16] Flags1 bit 7 capture h, bit 6 capture g; bits 12-8 unused.
// [R17] Flags1 bit 3 change notify, bit 1 I2C master, bit 0 I2C slave.
// [R18] Flags3 bit 15 pwm a fault, bit 10 encoder, bit 9 pwm a error.
// [R19] Flags4 bit 10 pwm b fault, bit 9 pwm b error, bit 1 UART error.
// [R20] Request passes on only when its enable bit is 1.
// [R21] Priority 000 disables a source; 1 to 7 pass, 7 highest. Here one priority field gates all 64 sources, with no ranking.
// [R22] Flags set regardless of enable; stay set until software writes 0.
// [R23] Source event in the cycle of a clearing write leaves the flag set.
`timescale 1ns/1ps
`default_nettype none
module ifcr_regs
	import ifcr_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	// Event pulses, one bit per flag position
	input  wire logic [15:0] src_evt0,
	input  wire logic [15:0] src_evt1,
	input  wire logic [15:0] src_evt3,
	input  wire logic [15:0] src_evt4,
	input  wire logic        stack_trap_evt,
	input  wire logic        osc_failure_trap_evt,
	input  wire logic        irq_disable_instr_active,
	// External interrupt pins, asynchronous
	input  wire logic [2:0]  ext_irq_pin,
	// To the core
	output logic             alt_vector_table_sel,
	output logic [63:0]      irq_pending
);

	typedef struct packed {
		logic        aw_got;
		logic [7:0]  aw_addr;
		logic        w_got;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [15:0] ctrl1;
		logic [15:0] ctrl2;
		logic [15:0] flags0;
		logic [15:0] flags1;
		logic [15:0] flags3;
		logic [15:0] flags4;
		logic [63:0] enable;
		logic [2:0]  prio;
		logic [2:0]  sync1;
		logic [2:0]  sync2;
		logic [2:0]  ext_prev;
		logic        alt_vec;
		logic [63:0] pending;
		logic        aw_rdy;
		logic        w_rdy;
		logic        ar_rdy;
	} ifcr_state_t;

	ifcr_state_t st_reg;
	ifcr_state_t st_next;

	// Software write: byte lanes of the low half only
	function automatic logic [15:0] ifcr_wr16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] strb, input logic [15:0] mask);
		logic [15:0] v;
		v = old;
		if (strb[0]) begin
			v[7:0] = d[7:0];
		end
		if (strb[1]) begin
			v[15:8] = d[15:8];
		end
		return v & mask;
	endfunction

	// One address decoder serves both the read and the write path
	typedef enum logic [3:0] {
		IFCR_SEL_CTRL1  = 4'h0,
		IFCR_SEL_CTRL2  = 4'h1,
		IFCR_SEL_FLAGS0 = 4'h2,
		IFCR_SEL_FLAGS1 = 4'h3,
		IFCR_SEL_FLAGS3 = 4'h4,
		IFCR_SEL_FLAGS4 = 4'h5,
		IFCR_SEL_EN0    = 4'h6,
		IFCR_SEL_EN1    = 4'h7,
		IFCR_SEL_EN3    = 4'h8,
		IFCR_SEL_EN4    = 4'h9,
		IFCR_SEL_PRIO   = 4'hA,
		IFCR_SEL_NONE   = 4'hF
	} ifcr_sel_t;

	function automatic ifcr_sel_t ifcr_decode(input logic [7:0] a);
		ifcr_sel_t s;
		if (a == IFCR_OFF_CTRL1) begin
			s = IFCR_SEL_CTRL1;
		end else if (a == IFCR_OFF_CTRL2) begin
			s = IFCR_SEL_CTRL2;
		end else if (a == IFCR_OFF_FLAGS0) begin
			s = IFCR_SEL_FLAGS0;
		end else if (a == IFCR_OFF_FLAGS1) begin
			s = IFCR_SEL_FLAGS1;
		end else if (a == IFCR_OFF_FLAGS3) begin
			s = IFCR_SEL_FLAGS3;
		end else if (a == IFCR_OFF_FLAGS4) begin
			s = IFCR_SEL_FLAGS4;
		end else if (a == IFCR_OFF_EN0) begin
			s = IFCR_SEL_EN0;
		end else if (a == IFCR_OFF_EN1) begin
			s = IFCR_SEL_EN1;
		end else if (a == IFCR_OFF_EN3) begin
			s = IFCR_SEL_EN3;
		end else if (a == IFCR_OFF_EN4) begin
			s = IFCR_SEL_EN4;
		end else if (a == IFCR_OFF_PRIO) begin
			s = IFCR_SEL_PRIO;
		end else begin
			s = IFCR_SEL_NONE;
		end
		return s;
	endfunction

	logic [2:0]  ext_edge;
	logic [15:0] ext0;
	logic [15:0] ext1;
	logic        wr_fire;
	logic        rd_fire;
	logic [15:0] rd_val;
	logic        rd_hit;
	logic        wr_hit;
	ifcr_sel_t   rd_sel;
	ifcr_sel_t   wr_sel;

	// Edge detect reads only the second synchroniser stage
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (st_reg.ctrl2[i]) begin
				ext_edge[i] = st_reg.ext_prev[i] & ~st_reg.sync2[i]; // [R5]
			end else begin
				ext_edge[i] = ~st_reg.ext_prev[i] & st_reg.sync2[i]; // [R5]
			end
		end
		ext0 = 16'h0000;
		ext1 = 16'h0000;
		ext0[IFCR_BIT_EXT0_FLAG] = ext_edge[0]; // [R15]
		ext1[IFCR_BIT_EXT1_FLAG] = ext_edge[1]; // [R15]
		ext1[IFCR_BIT_EXT2_FLAG] = ext_edge[2]; // [R15]
	end

	assign wr_fire = st_reg.aw_got & st_reg.w_got & ~st_reg.bvalid;
	assign rd_fire = s_arvalid & st_reg.ar_rdy;
	assign rd_sel = ifcr_decode(s_araddr);
	assign wr_sel = ifcr_decode(st_reg.aw_addr);

	always_comb begin
		rd_hit = 1'b1;
		if (rd_sel == IFCR_SEL_CTRL1) begin
			rd_val = st_reg.ctrl1;
		end else if (rd_sel == IFCR_SEL_CTRL2) begin
			rd_val = st_reg.ctrl2 & IFCR_MASK_CTRL2; // [R6]
		end else if (rd_sel == IFCR_SEL_FLAGS0) begin
			rd_val = st_reg.flags0;
		end else if (rd_sel == IFCR_SEL_FLAGS1) begin
			rd_val = st_reg.flags1;
		end else if (rd_sel == IFCR_SEL_FLAGS3) begin
			rd_val = st_reg.flags3;
		end else if (rd_sel == IFCR_SEL_FLAGS4) begin
			rd_val = st_reg.flags4;
		end else if (rd_sel == IFCR_SEL_EN0) begin
			rd_val = st_reg.enable[15:0];
		end else if (rd_sel == IFCR_SEL_EN1) begin
			rd_val = st_reg.enable[31:16];
		end else if (rd_sel == IFCR_SEL_EN3) begin
			rd_val = st_reg.enable[47:32];
		end else if (rd_sel == IFCR_SEL_EN4) begin
			rd_val = st_reg.enable[63:48];
		end else if (rd_sel == IFCR_SEL_PRIO) begin
			rd_val = {13'h0, st_reg.prio};
		end else begin
			rd_val = 16'h0000;
			rd_hit = 1'b0;
		end
	end

	always_comb begin
		st_next = st_reg;
		wr_hit = 1'b1;
		st_next.sync1 = ext_irq_pin;
		st_next.sync2 = st_reg.sync1;
		st_next.ext_prev = st_reg.sync2;

		// Write channels taken independently, in either order
		if (s_awvalid & st_reg.aw_rdy) begin
			st_next.aw_got = 1'b1;
			st_next.aw_addr = s_awaddr;
		end
		if (s_wvalid & st_reg.w_rdy) begin
			st_next.w_got = 1'b1;
			st_next.w_data = s_wdata;
			st_next.w_strb = s_wstrb;
		end

		// Software write first; hardware sets below so a set beats a clear
		if (wr_fire) begin
			if (wr_sel == IFCR_SEL_CTRL1) begin
				st_next.ctrl1 = ifcr_wr16(st_reg.ctrl1, st_reg.w_data, st_reg.w_strb, IFCR_MASK_CTRL1);
			end else if (wr_sel == IFCR_SEL_CTRL2) begin
				// Status bit 14 is not writable
				st_next.ctrl2 = ifcr_wr16(st_reg.ctrl2, st_reg.w_data, st_reg.w_strb, IFCR_MASK_CTRL2W); // [R4] [R6]
			end else if (wr_sel == IFCR_SEL_FLAGS0) begin
				st_next.flags0 = ifcr_wr16(st_reg.flags0, st_reg.w_data, st_reg.w_strb, IFCR_MASK_FLAGS0); // [R7]
			end else if (wr_sel == IFCR_SEL_FLAGS1) begin
				st_next.flags1 = ifcr_wr16(st_reg.flags1, st_reg.w_data, st_reg.w_strb, IFCR_MASK_FLAGS1); // [R7]
			end else if (wr_sel == IFCR_SEL_FLAGS3) begin
				st_next.flags3 = ifcr_wr16(st_reg.flags3, st_reg.w_data, st_reg.w_strb, IFCR_MASK_FLAGS3); // [R7]
			end else if (wr_sel == IFCR_SEL_FLAGS4) begin
				st_next.flags4 = ifcr_wr16(st_reg.flags4, st_reg.w_data, st_reg.w_strb, IFCR_MASK_FLAGS4); // [R7]
			end else if (wr_sel == IFCR_SEL_EN0) begin
				st_next.enable[15:0] = ifcr_wr16(st_reg.enable[15:0], st_reg.w_data, st_reg.w_strb, IFCR_MASK_FLAGS0);
			end else if (wr_sel == IFCR_SEL_EN1) begin
				st_next.enable[31:16] = ifcr_wr16(st_reg.enable[31:16], st_reg.w_data, st_reg.w_strb, IFCR_MASK_FLAGS1);
			end else if (wr_sel == IFCR_SEL_EN3) begin
				st_next.enable[47:32] = ifcr_wr16(st_reg.enable[47:32], st_reg.w_data, st_reg.w_strb, IFCR_MASK_FLAGS3);
			end else if (wr_sel == IFCR_SEL_EN4) begin
				st_next.enable[63:48] = ifcr_wr16(st_reg.enable[63:48], st_reg.w_data, st_reg.w_strb, IFCR_MASK_FLAGS4);
			end else if (wr_sel == IFCR_SEL_PRIO) begin
				if (st_reg.w_strb[0]) begin
					st_next.prio = st_reg.w_data[2:0];
				end
			end else begin
				wr_hit = 1'b0;
			end
			st_next.aw_got = 1'b0;
			st_next.w_got = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = wr_hit ? IFCR_RESP_OKAY : IFCR_RESP_SLVERR;
		end
		if (st_reg.bvalid & s_bready) begin
			st_next.bvalid = 1'b0;
		end

		// Hardware sets, independent of enables, sticky until written 0, except status bit 14 which follows its input
		st_next.ctrl1[IFCR_BIT_STACK_TRAP] = st_next.ctrl1[IFCR_BIT_STACK_TRAP] | stack_trap_evt; // [R1] [R23]
		st_next.ctrl1[IFCR_BIT_OSC_TRAP] = st_next.ctrl1[IFCR_BIT_OSC_TRAP] | osc_failure_trap_evt; // [R2] [R23]
		st_next.ctrl2[IFCR_BIT_DIS_INSTR] = irq_disable_instr_active; // [R4]
		st_next.flags0 = st_next.flags0 | ((src_evt0 | ext0) & IFCR_MASK_FLAGS0); // [R9] [R10] [R11] [R12] [R13] [R14] [R22] [R23]
		st_next.flags1 = st_next.flags1 | ((src_evt1 | ext1) & IFCR_MASK_FLAGS1); // [R15] [R16] [R17] [R22] [R23]
		st_next.flags3 = st_next.flags3 | (src_evt3 & IFCR_MASK_FLAGS3); // [R18] [R22] [R23]
		st_next.flags4 = st_next.flags4 | (src_evt4 & IFCR_MASK_FLAGS4); // [R19] [R22] [R23]

		st_next.alt_vec = st_reg.ctrl2[IFCR_BIT_ALT_VEC]; // [R3]
		// Only enabled flags with nonzero priority reach the core
		if (st_reg.prio == IFCR_PRIO_OFF) begin
			st_next.pending = 64'h0000000000000000; // [R21]
		end else begin
			st_next.pending = {st_reg.flags4, st_reg.flags3, st_reg.flags1, st_reg.flags0} & st_reg.enable; // [R20]
		end

		if (rd_fire) begin
			st_next.rvalid = 1'b1;
			st_next.rdata = {16'h0000, rd_val};
			st_next.rresp = rd_hit ? IFCR_RESP_OKAY : IFCR_RESP_SLVERR;
		end else if (st_reg.rvalid & s_rready) begin
			st_next.rvalid = 1'b0;
		end

		// Ready flags are registered so every bus output leaves a flip-flop; low during reset
		st_next.aw_rdy = ~st_next.aw_got;
		st_next.w_rdy = ~st_next.w_got;
		st_next.ar_rdy = ~st_next.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0; // [R8]
		end else begin
			st_reg <= st_next;
		end
	end

	assign s_awready = st_reg.aw_rdy;
	assign s_wready = st_reg.w_rdy;
	assign s_bvalid = st_reg.bvalid;
	assign s_bresp = st_reg.bresp;
	assign s_arready = st_reg.ar_rdy;
	assign s_rvalid = st_reg.rvalid;
	assign s_rdata = st_reg.rdata;
	assign s_rresp = st_reg.rresp;
	assign alt_vector_table_sel = st_reg.alt_vec;
	assign irq_pending = st_reg.pending;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	sequence ifcr_seq_clear0;
		wr_fire && st_reg.aw_addr == IFCR_OFF_FLAGS0 && st_reg.w_strb[0] && !st_reg.w_data[1];
	endsequence

	chk_stack_set: assert property (@(posedge aclk) disable iff (!aresetn)
		stack_trap_evt |=> st_reg.ctrl1[2]) else $error("stack trap bit not set"); // [R1]
	chk_osc_set: assert property (@(posedge aclk) disable iff (!aresetn)
		osc_failure_trap_evt |=> st_reg.ctrl1[1]) else $error("osc trap bit not set"); // [R2]
	chk_alt_vector: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 alt_vector_table_sel == $past(st_reg.ctrl2[15])) else $error("vector select mismatch"); // [R3]
	chk_disable_status: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 st_reg.ctrl2[14] == $past(irq_disable_instr_active)) else $error("disable status wrong"); // [R4]
	chk_ctrl2_unused: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg.ctrl2 & 16'h3FF8) == 16'h0000) else $error("unused control bits set"); // [R6]
	chk_flags_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		st_reg.flags0[13] && !(wr_fire && st_reg.aw_addr == IFCR_OFF_FLAGS0) |=> st_reg.flags0[13])
		else $error("flag lost without write"); // [R22]
	chk_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
		ifcr_seq_clear0 and src_evt0[1] |=> st_reg.flags0[1]) else $error("event lost on clear"); // [R23]
	chk_pending_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		!st_reg.enable[0] |=> !irq_pending[0]) else $error("disabled request passed"); // [R20]
	chk_prio_off: assert property (@(posedge aclk) disable iff (!aresetn)
		st_reg.prio == 3'h0 |=> irq_pending == 64'h0) else $error("priority zero passed"); // [R21]
	chk_unused_flags: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_reg.flags1 & ~IFCR_MASK_FLAGS1) == 16'h0000) else $error("unused flag set"); // [R16]

	// Pin edges are judged after two synchroniser stages, with the polarity then in force
	sequence ifcr_seq_rise0;
		$rose(st_reg.sync2[0]) && !st_reg.ctrl2[0];
	endsequence
	sequence ifcr_seq_fall2;
		$fell(st_reg.sync2[2]) && st_reg.ctrl2[2];
	endsequence

	chk_ext0_rise: assert property (@(posedge aclk) disable iff (!aresetn) // [R5] [R15]
		ifcr_seq_rise0 |=> st_reg.flags0[0]) else $error("rising edge missed");
	chk_ext2_fall: assert property (@(posedge aclk) disable iff (!aresetn) // [R5] [R15]
		ifcr_seq_fall2 |=> st_reg.flags1[13]) else $error("falling edge missed");
	chk_ctrl1_unused: assert property (@(posedge aclk) disable iff (!aresetn) // [R8]
		(st_reg.ctrl1 & 16'hFFF9) == 16'h0000) else $error("unused trap bits set");
	chk_flags0_unused: assert property (@(posedge aclk) disable iff (!aresetn) // [R9] [R12]
		(st_reg.flags0 & 16'hC010) == 16'h0000) else $error("unused flag bits set in first group");
	chk_flags3_unused: assert property (@(posedge aclk) disable iff (!aresetn) // [R18]
		(st_reg.flags3 & 16'h79FF) == 16'h0000) else $error("unused flag bits set in third group");
	chk_flags4_unused: assert property (@(posedge aclk) disable iff (!aresetn) // [R19]
		(st_reg.flags4 & 16'hF9FD) == 16'h0000) else $error("unused flag bits set in fourth group");
	chk_flag3_set: assert property (@(posedge aclk) disable iff (!aresetn) // [R18] [R22]
		src_evt3[15] |=> st_reg.flags3[15]) else $error("fault event not latched");
	chk_read_answer: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
		s_arvalid && s_arready |=> s_rvalid && !s_arready) else $error("read not answered");

endmodule
`default_nettype wire

// ===== tb/ifcr_src_model.sv
// Behavioural model of the peripheral request sources and the trap logic.
// Assumes the bench raises go for one aclk cycle with the event pattern beside it.
`timescale 1ns/1ps
`default_nettype none
module ifcr_src_model (
	// Bench control
	input  wire logic        aclk,
	input  wire logic        go,
	input  wire logic [65:0] pat,
	// Request pulses into the register block
	output logic [15:0]      src_evt0,
	output logic [15:0]      src_evt1,
	output logic [15:0]      src_evt3,
	output logic [15:0]      src_evt4,
	output logic             stack_trap_evt,
	output logic             osc_failure_trap_evt
);
	// Unimplemented positions pulse too, so the block must prove it drops them
	always_ff @(posedge aclk) begin
		{osc_failure_trap_evt, stack_trap_evt, src_evt4, src_evt3, src_evt1, src_evt0} <= go ? pat : 66'h0;
	end
endmodule
`default_nettype wire

// ===== tb/tb_interrupt_flag_and_control_regs.sv
// Self-checking bench for the interrupt flag and control registers.
// Assumes ifcr_pkg, ifcr_regs and ifcr_src_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_flag_and_control_regs
	import ifcr_pkg::*;
;
	logic        aclk, aresetn, go, irq_disable_instr_active, stack_trap_evt, osc_failure_trap_evt;
	logic        s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, alt_vector_table_sel;
	logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [7:0]  s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata, seed;
	logic [3:0]  s_wstrb;
	logic [1:0]  s_bresp, s_rresp;
	logic [15:0] src_evt0, src_evt1, src_evt3, src_evt4;
	logic [2:0]  ext_irq_pin, pr;
	logic [63:0] irq_pending, fl;
	logic [65:0] pat, p;
	int          num_errors, comparisons, cycles;
	localparam logic [7:0]  OFFS [6] = '{IFCR_OFF_CTRL1, IFCR_OFF_CTRL2, IFCR_OFF_FLAGS0,
		IFCR_OFF_FLAGS1, IFCR_OFF_FLAGS3, IFCR_OFF_FLAGS4};
	localparam logic [7:0]  ENS [4] = '{IFCR_OFF_EN0, IFCR_OFF_EN1, IFCR_OFF_EN3, IFCR_OFF_EN4};
	// Software-writable bits, in the order of OFFS
	localparam logic [15:0] WM [6] = '{16'h0006, 16'h8007, 16'h3FEF, 16'h20DB, 16'h8600, 16'h0602};

	ifcr_regs dut_u (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
		.s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
		.src_evt0, .src_evt1, .src_evt3, .src_evt4, .stack_trap_evt, .osc_failure_trap_evt, .irq_disable_instr_active,
		.ext_irq_pin, .alt_vector_table_sel, .irq_pending);
	ifcr_src_model src_u (.aclk, .go, .pat, .src_evt0, .src_evt1, .src_evt3, .src_evt4, .stack_trap_evt,
		.osc_failure_trap_evt);
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	// The whole run needs under a thousand cycles
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			summarize();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Address and data offered together, each released once taken
	task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = IFCR_RESP_OKAY);
		logic aw, w;
		@(posedge aclk);
		aw = 1'b1;
		w = 1'b1;
		s_awaddr <= a;
		s_wdata <= {16'h0000, d};
		s_wstrb <= 4'h3;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && s_awready) begin
				aw = 1'b0;
				s_awvalid <= 1'b0;
			end
			if (w && s_wready) begin
				w = 1'b0;
				s_wvalid <= 1'b0;
			end
		end
		while (!s_bvalid) @(posedge aclk);
		chk({62'h0, s_bresp}, {62'h0, er}, "write response");
		s_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [15:0] ed, input logic [1:0] er = IFCR_RESP_OKAY);
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		@(posedge aclk);
		while (!s_arready) @(posedge aclk);
		s_arvalid <= 1'b0;
		@(posedge aclk);
		while (!s_rvalid) @(posedge aclk);
		chk({62'h0, s_rresp}, {62'h0, er}, "read response");
		if (er === IFCR_RESP_OKAY) chk({32'h0, s_rdata}, {48'h0, ed}, "read data");
		s_rready <= 1'b0;
	endtask
	task automatic pulse(input logic [65:0] q);
		@(posedge aclk);
		pat <= q;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		repeat (3) @(posedge aclk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{aresetn, go, irq_disable_instr_active, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 8'h00;
		{s_awaddr, s_araddr, s_wdata, s_wstrb, ext_irq_pin, pat} = '0;
		seed = 32'h00016CD8;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 6; i++) axi_rd(OFFS[i], 16'h0000);
		axi_rd(8'hFC, 16'h0000, IFCR_RESP_SLVERR);
		axi_wr(8'hFC, 16'hFFFF, IFCR_RESP_SLVERR);
		$display("test reset values done");
		// Status bit and holes must stay 0 when software writes ones
		for (int i = 0; i < 6; i++) begin
			axi_wr(OFFS[i], 16'hFFFF);
			axi_rd(OFFS[i], WM[i]);
		end
		chk({63'h0, alt_vector_table_sel}, 64'h1, "alternate table");
		for (int i = 0; i < 6; i++) begin
			axi_wr(OFFS[i], 16'h0000);
			axi_rd(OFFS[i], 16'h0000);
		end
		chk({63'h0, alt_vector_table_sel}, 64'h0, "default table");
		$display("test register access done");
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			p[31:0] = seed;
			seed = lfsr(seed);
			p[65:32] = {seed[1:0], seed};
			fl = p[63:0] & {WM[5], WM[4], WM[3], WM[2]};
			pr = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : seed[4:2];
			pulse(p);
			for (int k = 0; k < 4; k++) axi_rd(OFFS[k + 2], fl[16 * k +: 16]);
			axi_rd(IFCR_OFF_CTRL1, {13'h0, p[64], p[65], 1'b0});
			for (int k = 0; k < 4; k++) axi_wr(ENS[k], (i % 3 == 2) ? 16'h0000 : 16'hFFFF);
			axi_wr(IFCR_OFF_PRIO, {13'h0, pr});
			repeat (2) @(posedge aclk);
			chk(irq_pending, (i % 3 == 2 || pr == 3'h0) ? 64'h0 : fl, "pending");
			for (int k = 0; k < 6; k++) axi_wr(OFFS[k], 16'h0000);
		end
		$display("test random events done");
		// The event pulse lands in the very cycle in which the clearing write is applied
		fork
			axi_wr(IFCR_OFF_FLAGS0, 16'h0000);
			pulse(66'h2);
		join
		axi_rd(IFCR_OFF_FLAGS0, 16'h0002);
		fork
			axi_wr(IFCR_OFF_CTRL1, 16'h0000);
			pulse(66'h10000000000000000);
		join
		axi_rd(IFCR_OFF_CTRL1, 16'h0004);
		axi_wr(IFCR_OFF_FLAGS0, 16'h0000);
		axi_wr(IFCR_OFF_CTRL1, 16'h0000);
		$display("test set beats clear done");
		irq_disable_instr_active <= 1'b1;
		axi_wr(IFCR_OFF_CTRL2, 16'h0000);
		axi_rd(IFCR_OFF_CTRL2, 16'h4000);
		irq_disable_instr_active <= 1'b0;
		axi_rd(IFCR_OFF_CTRL2, 16'h0000);
		$display("test disable status done");
		for (int pol = 0; pol < 2; pol++) begin
			axi_wr(IFCR_OFF_CTRL2, (pol == 1) ? 16'h0007 : 16'h0000);
			axi_wr(IFCR_OFF_FLAGS0, 16'h0000);
			axi_wr(IFCR_OFF_FLAGS1, 16'h0000);
			ext_irq_pin <= (pol == 1) ? 3'h0 : 3'h7;
			repeat (6) @(posedge aclk);
			axi_rd(IFCR_OFF_FLAGS0, 16'h0001);
			axi_rd(IFCR_OFF_FLAGS1, 16'h2010);
		end
		$display("test external edges done");
		summarize();
	end
endmodule
`default_nettype wire
